//--- rtl/god_defs.vh
// Register offsets, field positions and reset values of the output-override and debounce block
// Functional notes
// [R1] With the bank select at push-pull, an override bit of 1 turns only that pin's stage to open-drain.
// [R2] With the bank select at open-drain, an override bit of 1 turns only that pin's stage to push-pull.
// [R3] The host should program the bank select, then the override bits, then the direction registers.
// [R4] The fifth port's override register keeps only bits 1 and 0, reset to 0, upper bits unused.
// [R5] An input pin of the first two ports with its debounce enable bit set goes through a debouncer.
// [R6] A pin set as output bypasses the debouncer whatever its enable bit holds.
// [R7] The first pin of the third port is the time base for every debounce counter.
// [R8] If the time-base pin is not an input, no pin is connected to debounce logic.
// [R9] The qualification period is the count register value times the time-base period; the code updates on tick count+1 after the last change.
// [R10] The debouncer decides a settled open (1) or closed (0) level before passing it on.
// [R11] Five read-only live-level registers sit at consecutive addresses, the fifth with two bits.
// [R12] A live-level read returns the present pin state and disturbs no interrupt logic.
// [R13] An output pin with an open-drain stage reads 0 in its live-level bit.
// [R14] Each debouncer restarts on any input change and updates only after a full stable period.
// [R15] The debounced level of an enabled pin replaces the raw level on the input-port path.
`ifndef GOD_DEFS_VH
`define GOD_DEFS_VH
`define GOD_ADDR_LIVE0     8'h63
`define GOD_ADDR_LIVE1     8'h64
`define GOD_ADDR_LIVE2     8'h65
`define GOD_ADDR_LIVE3     8'h66
`define GOD_ADDR_LIVE4     8'h67
`define GOD_ADDR_OVR0      8'h68
`define GOD_ADDR_OVR1      8'h69
`define GOD_ADDR_OVR2      8'h6A
`define GOD_ADDR_OVR3      8'h6B
`define GOD_ADDR_OVR4      8'h6C
`define GOD_ADDR_DBEN0     8'h6D
`define GOD_ADDR_DBEN1     8'h6E
`define GOD_ADDR_DBCNT     8'h6F
`define GOD_RST_OVR        8'h00
`define GOD_RST_DBEN       8'h00
`define GOD_RST_DBCNT      8'h00
`define GOD_PORT4_MASK     8'h03
`define GOD_TIMEBASE_PIN   16
`endif

//--- rtl/god_gpio_outcfg_debounce.v
// Output-stage override, live-level readback and switch debounce for a 34-pin expander
`include "god_defs.vh"

module god_gpio_outcfg_debounce (
	// Clock and reset
	input  wire        sys_clk_in,
	input  wire        nrst_in,
	// Register port from the serial slave
	input  wire        reg_wr_in,
	input  wire [7:0]  reg_addr_in,
	input  wire [7:0]  reg_wdata_in,
	output reg  [7:0]  reg_rdata_out,
	output wire        reg_hit_out,
	// Expander state from neighbouring registers
	input  wire [4:0]  bank_open_drain_select_in,
	input  wire [33:0] pin_is_input_in,
	input  wire [33:0] pin_level_in,
	// Pin stage and input-path results
	output wire [33:0] pin_open_drain_out,
	output reg  [33:0] pin_input_level_out,
	output wire [15:0] debounce_active_out
);

	// Override, enable and count storage
	reg  [7:0]  ovr_q [0:4];
	reg  [7:0]  dben0_q;
	reg  [7:0]  dben1_q;
	reg  [7:0]  dbcnt_q;
	// Time-base edge tracking
	reg  [1:0]  tb_hist_q;
	wire        tb_tick;
	wire        tb_usable;
	wire [33:0] ovr_flat;
	wire [15:0] dben_all;
	wire [15:0] db_level;
	wire [33:0] live_level;
	integer     i;
	// Separate loop index so each process owns its own variable
	integer     j;

	assign ovr_flat = {ovr_q[4][1:0], ovr_q[3], ovr_q[2], ovr_q[1], ovr_q[0]};
	assign dben_all = {dben1_q, dben0_q};

	// Register writes; port 4 keeps only two bits
	always @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			for (i = 0; i < 5; i = i + 1) begin
				ovr_q[i] <= `GOD_RST_OVR;
			end
			dben0_q <= `GOD_RST_DBEN;
			dben1_q <= `GOD_RST_DBEN;
			dbcnt_q <= `GOD_RST_DBCNT;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				`GOD_ADDR_OVR0: ovr_q[0] <= reg_wdata_in;
				`GOD_ADDR_OVR1: ovr_q[1] <= reg_wdata_in;
				`GOD_ADDR_OVR2: ovr_q[2] <= reg_wdata_in;
				`GOD_ADDR_OVR3: ovr_q[3] <= reg_wdata_in;
				`GOD_ADDR_OVR4: ovr_q[4] <= reg_wdata_in & `GOD_PORT4_MASK; // [R4]
				`GOD_ADDR_DBEN0: dben0_q <= reg_wdata_in;
				`GOD_ADDR_DBEN1: dben1_q <= reg_wdata_in;
				`GOD_ADDR_DBCNT: dbcnt_q <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	// Stage per pin: bank select flipped by override bit
	genvar p;
	generate
		for (p = 0; p < 34; p = p + 1) begin : g_stage
			assign pin_open_drain_out[p] = bank_open_drain_select_in[p / 8] ^ ovr_flat[p]; // [R1] [R2]
			// Output in open-drain reads 0, otherwise the pin itself
			assign live_level[p] = (!pin_is_input_in[p] && pin_open_drain_out[p]) ? 1'b0 : pin_level_in[p]; // [R13]
		end
	endgenerate

	// Rising edge of the time-base pin; sampled as a plain synchronous input
	always @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tb_hist_q <= 2'b00;
		end else begin
			tb_hist_q <= {tb_hist_q[0], pin_level_in[`GOD_TIMEBASE_PIN]}; // [R7]
		end
	end
	assign tb_tick   = tb_hist_q[0] & ~tb_hist_q[1];
	assign tb_usable = pin_is_input_in[`GOD_TIMEBASE_PIN]; // [R8]

	// One debouncer per pin of ports 0 and 1
	genvar d;
	generate
		for (d = 0; d < 16; d = d + 1) begin : g_db
			reg [7:0] cnt_q;
			reg       prev_q;
			reg       out_q;
			assign debounce_active_out[d] = dben_all[d] & pin_is_input_in[d] & tb_usable; // [R5] [R6] [R8]
			always @(posedge sys_clk_in or negedge nrst_in) begin
				if (!nrst_in) begin
					cnt_q  <= 8'h00;
					prev_q <= 1'b1;
					out_q  <= 1'b1;
				end else begin
					prev_q <= pin_level_in[d];
					if (pin_level_in[d] != prev_q) begin
						cnt_q <= 8'h00; // [R14]
					end else if (tb_tick) begin
						// Count of N passes on the N+1th stable time-base tick; zero passes on the next tick
						if (cnt_q >= dbcnt_q) begin // [R9]
							out_q <= prev_q; // [R10] [R14]
						end else begin
							cnt_q <= cnt_q + 8'h01;
						end
					end
				end
			end
			assign db_level[d] = out_q;
		end
	endgenerate

	// Input path: debounced level replaces the raw one where active
	always @* begin
		pin_input_level_out = pin_level_in;
		for (j = 0; j < 16; j = j + 1) begin
			if (debounce_active_out[j]) begin
				pin_input_level_out[j] = db_level[j]; // [R15]
			end
		end
	end

	// Read mux; no side effects on any read
	assign reg_hit_out = (reg_addr_in >= `GOD_ADDR_LIVE0) && (reg_addr_in <= `GOD_ADDR_DBCNT);
	always @* begin
		case (reg_addr_in)
			`GOD_ADDR_LIVE0: reg_rdata_out = live_level[7:0]; // [R11] [R12]
			`GOD_ADDR_LIVE1: reg_rdata_out = live_level[15:8];
			`GOD_ADDR_LIVE2: reg_rdata_out = live_level[23:16];
			`GOD_ADDR_LIVE3: reg_rdata_out = live_level[31:24];
			`GOD_ADDR_LIVE4: reg_rdata_out = {6'h00, live_level[33:32]};
			`GOD_ADDR_OVR0:  reg_rdata_out = ovr_q[0];
			`GOD_ADDR_OVR1:  reg_rdata_out = ovr_q[1];
			`GOD_ADDR_OVR2:  reg_rdata_out = ovr_q[2];
			`GOD_ADDR_OVR3:  reg_rdata_out = ovr_q[3];
			`GOD_ADDR_OVR4:  reg_rdata_out = ovr_q[4];
			`GOD_ADDR_DBEN0: reg_rdata_out = dben0_q;
			`GOD_ADDR_DBEN1: reg_rdata_out = dben1_q;
			`GOD_ADDR_DBCNT: reg_rdata_out = dbcnt_q;
			default:         reg_rdata_out = 8'h00;
		endcase
	end

endmodule

//--- tb/god_osc_model.sv
// Time-base oscillator model at the far side of the debounce pin
module god_osc_model (
	input  logic sys_clk_in,
	input  logic run_in,
	output logic osc_out = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	// Period of 8 clocks while running; rests low otherwise so no stray ticks
	always @(negedge sys_clk_in) begin
		cnt = run_in ? cnt + 1 : 0;
		osc_out <= run_in && cnt[2];
	end
endmodule

//--- tb/god_checker.sv
// Port assertions for the override and debounce block
module god_checker (
	input logic        sys_clk_in, nrst_in, reg_wr_in, reg_hit_out,
	input logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out,
	input logic [4:0]  bank_open_drain_select_in,
	input logic [33:0] pin_is_input_in, pin_level_in, pin_open_drain_out, pin_input_level_out,
	input logic [15:0] debounce_active_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);
	sequence s_ovr0_wr;
		reg_wr_in && reg_addr_in == 8'h68 ##1 $stable(bank_open_drain_select_in[0]);
	endsequence
	a_stage_invert: assert property (s_ovr0_wr |->
		pin_open_drain_out[7:0] == ($past(reg_wdata_in) ^ {8{bank_open_drain_select_in[0]}})) else $error("stage");
	a_port4_mask: assert property (reg_addr_in == 8'h6C |-> reg_rdata_out[7:2] == 6'h00) else $error("ovr4");
	a_live4_mask: assert property (reg_addr_in == 8'h67 |-> reg_rdata_out[7:2] == 6'h00) else $error("live4");
	a_hit_range: assert property (reg_hit_out == (reg_addr_in inside {[8'h63:8'h6F]})) else $error("hit");
	a_miss_zero: assert property (!reg_hit_out |-> reg_rdata_out == 8'h00) else $error("miss");
	a_od_zero: assert property (reg_addr_in == 8'h63 && !pin_is_input_in[1] && pin_open_drain_out[1]
		|-> !reg_rdata_out[1]) else $error("od read");
	a_live_follow: assert property (reg_addr_in == 8'h63 && pin_is_input_in[2]
		|-> reg_rdata_out[2] == pin_level_in[2]) else $error("live");
	a_out_bypass: assert property (!pin_is_input_in[0] |-> !debounce_active_out[0]) else $error("bypass");
	a_base_off: assert property (!pin_is_input_in[16] |-> debounce_active_out == 16'h0000) else $error("base");
	a_settle_hold: assert property ($changed(pin_input_level_out[0]) && debounce_active_out[0] &&
		$past(debounce_active_out[0]) |-> pin_input_level_out[0] == $past(pin_level_in[0])) else $error("hold");
endmodule
bind god_gpio_outcfg_debounce god_checker u_chk (.*);

//--- tb/testbench.sv
// Directed register and debounce tests for the override block
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
	$display("wrong value at %0t: %h vs %h", $time, a, b); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk_in = 0, nrst_in = 0, reg_wr_in = 0, run = 0, reg_hit_out, osc;
	logic [7:0]  reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
	logic [4:0]  bank_open_drain_select_in = 5'h00;
	logic [33:0] pin_is_input_in = {34{1'b1}}, pins = {34{1'b1}}, pin_open_drain_out, pin_input_level_out;
	logic [15:0] debounce_active_out;
	wire  [33:0] pin_level_in = {pins[33:17], osc, pins[15:0]};
	int          err_total = 0, total_checks = 0, i;
	god_gpio_outcfg_debounce u_dut (.*);
	god_osc_model u_osc (.sys_clk_in(sys_clk_in), .run_in(run), .osc_out(osc));
	initial forever #12.5 sys_clk_in = ~sys_clk_in;
	// Strobe held across one rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk_in);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = 1;
		@(negedge sys_clk_in);
		reg_wr_in = 0;
	endtask
	// Read data is combinational, so sample after settling
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge sys_clk_in);
		reg_addr_in = a;
		#1 `CHK(reg_rdata_out, e)
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#100us err_total++;
		print_verdict();
	end
	initial begin
		repeat (2) @(negedge sys_clk_in);
		nrst_in = 1;
		for (i = 8'h68; i <= 8'h6F; i++) rd(i[7:0], 8'h00);
		$display("test reset done");
		wr(8'h68, 8'hA5);
		#1 `CHK(pin_open_drain_out[7:0], 8'hA5)
		bank_open_drain_select_in = 5'h01;
		#1 `CHK(pin_open_drain_out[7:0], 8'h5A)
		wr(8'h6C, 8'hFF);
		rd(8'h6C, 8'h03);
		`CHK(pin_open_drain_out[33:32], 2'h3)
		pin_is_input_in[1] = 0;
		rd(8'h63, 8'hFD);
		wr(8'h63, 8'h00);
		rd(8'h63, 8'hFD);
		rd(8'h67, 8'h03);
		rd(8'h70, 8'h00);
		`CHK(reg_hit_out, 1'b0)
		pin_is_input_in[1] = 1;
		$display("test stage done");
		wr(8'h6D, 8'h01);
		wr(8'h6F, 8'h02);
		rd(8'h6D, 8'h01);
		rd(8'h6F, 8'h02);
		run = 1;
		#1 `CHK(debounce_active_out, 16'h0001)
		pins[0] = 0;
		repeat (8) @(negedge sys_clk_in);
		`CHK(pin_input_level_out[0], 1'b1)
		for (i = 0; i < 100 && pin_input_level_out[0] !== 1'b0; i++) @(negedge sys_clk_in);
		if (i == 100) begin
			err_total++;
			print_verdict();
		end
		`CHK(i >= 8, 1'b1)
		pin_is_input_in[0] = 0;
		#1 `CHK(debounce_active_out[0], 1'b0)
		pin_is_input_in = {34{1'b1}} ^ (34'h1 << 16);
		pins[0] = 1;
		#1 `CHK(debounce_active_out, 16'h0000)
		`CHK(pin_input_level_out[0], 1'b1)
		$display("test debounce done");
		print_verdict();
	end
endmodule
